// File: sim/sac_core_model.sv
`timescale 1ns/1ps
// Analog core stand-in: a held input level weighed against the trial code.
module sac_core_model (
    input wire logic clk,
    input wire sac_pkg::sac_mux_s muxSel,
    input wire logic [11:0] dacCode,
    input wire logic [11:0] level,
    output logic cmpOut
);
    import sac_pkg::*;
    // Toggling node; an open input must not read as a steady level.
    logic wander = 1'b0;
    //////////////////////////////////////////////////
    // Free-running pattern for the unconnected case.
    always_ff @(posedge clk) begin
        wander <= ~wander;
    end
    assign cmpOut = muxSel.on ? (level >= dacCode) : wander;
endmodule : sac_core_model

// File: sim/sac_sva.sv
`timescale 1ns/1ps
// Port-level watcher for the converter control block.
module sac_sva #(
    parameter int INSTR_DIV = 4
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic globalIrqEnable,
    input wire logic convIrq,
    input wire logic coreEnable,
    input wire logic sampling,
    input wire sac_pkg::sac_ref_s refSel,
    input wire sac_pkg::sac_mux_s muxSel
);
    import sac_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    // Eight periods of the slowest converter clock, with one period of slack.
    localparam int SAMPLE_MAX = 9 * 16 * INSTR_DIV;
    // Length of the sampling window seen so far.
    int sampleCnt;
    //////////////////////////////////////////////////
    // Counts window cycles; a counter avoids a long repetition.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sampleCnt <= 0;
        end else begin
            sampleCnt <= sampling ? sampleCnt + 1 : 0;
        end
    end
    //////////////////////////////////////////////////
    // Setup and access phases of one bus transfer.
    sequence apb_setup;
        psel && !penable;
    endsequence
    sequence apb_access;
        psel && penable;
    endsequence
    a_access_answered: assert property (apb_setup ##1 apb_access |-> pready)
        else $error("access cycle without ready");
    a_ready_single: assert property (pready |=> !pready)
        else $error("ready held past one cycle");
    a_ref_ext_only: assert property (refSel.ext |-> refSel.intSel == 2'h0)
        else $error("internal ref select leaks under external ref");
    a_mux_in_range: assert property (muxSel.on |-> muxSel.sel <= 4'hB)
        else $error("mux connected on an empty code");
    a_irq_needs_global: assert property (convIrq |-> $past(globalIrqEnable))
        else $error("interrupt without global enable");
    a_irq_global_drop: assert property (!globalIrqEnable |=> !convIrq)
        else $error("interrupt stays up after global mask");
    a_window_min: assert property ($rose(sampling) |-> (sampling || !coreEnable) [*4])
        else $error("sampling window shorter than one period");
    a_window_max: assert property (sampleCnt <= SAMPLE_MAX)
        else $error("sampling window longer than eight periods");
    a_idle_when_off: assert property (!coreEnable && !$past(coreEnable) |-> !sampling)
        else $error("sampling while converter disabled");
    a_irq_after_window: assert property ($rose(convIrq) |-> !sampling)
        else $error("end event raised during sampling");
endmodule : sac_sva

bind sac_top sac_sva #(.INSTR_DIV(INSTR_DIV)) sac_sva_inst (.clk(clk), .rstn(rstn), .psel(psel),
    .penable(penable), .pready(pready), .globalIrqEnable(globalIrqEnable), .convIrq(convIrq),
    .coreEnable(coreEnable), .sampling(sampling), .refSel(refSel), .muxSel(muxSel));

// File: sim/testbench.sv
`timescale 1ns/1ps
module testbench;
    import sac_pkg::*;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic globalIrqEnable = 1'b1;
    logic cmpOut;
    logic convIrq;
    logic coreEnable;
    logic sampling;
    logic [11:0] dacCode;
    sac_ref_s refSel;
    sac_mux_s muxSel;
    logic [10:0] pinAnalog;
    // Analog level offered on the selected input.
    logic [11:0] level = 12'hA5C;
    int n_fail = 0;
    int checked = 0;
    int cyc = 0;
    logic [31:0] rdata;
    logic rerr;
    // Divisor, window periods and bit count per field code.
    int dv[4] = '{16, 8, 1, 2};
    int sw[4] = '{1, 2, 4, 8};
    int nb[4] = '{8, 10, 12, 12};
    //////////////////////////////////////////////////
    always #25 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;
    sac_top #(.INSTR_DIV(4)) sac_top_inst (.clk(clk), .rstn(rstn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .globalIrqEnable(globalIrqEnable),
        .cmpOut(cmpOut), .convIrq(convIrq), .coreEnable(coreEnable), .sampling(sampling),
        .dacCode(dacCode), .refSel(refSel), .muxSel(muxSel), .pinAnalog(pinAnalog));
    sac_core_model sac_core_model_inst (.clk(clk), .muxSel(muxSel), .dacCode(dacCode),
        .level(level), .cmpOut(cmpOut));
    //////////////////////////////////////////////////
    task automatic print_verdict();
        $display("checked %0d, n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : print_verdict
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : chk
    // One bus transfer; ready, read data and error are taken at one rising edge.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n >= 16) begin
            chk(0, 1, "bus timeout");
            print_verdict();
        end
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string msg);
        apb(1'b0, a, 32'h0);
        chk(rdata, exp, msg);
    endtask : rd
    task automatic wt(input int n);
        repeat (n) @(negedge clk);
    endtask : wt
    // Runs one conversion; a second start mid-run must not lengthen it.
    task automatic conv(input int k, input int s, input int r, input bit again);
        int t0;
        int ex;
        int n = 0;
        ex = (sw[s] + nb[r] + 2) * 4 * dv[k];
        apb(1'b1, TIMING_OFS, 32'(s * 4 + k));
        apb(1'b1, CONV_CONTROL_OFS, 32'(8'h84 + r));
        t0 = cyc;
        rd(CONV_CONTROL_OFS, 32'(8'h80 + r), "end flag busy");
        if (again) begin
            wt(ex / 2);
            apb(1'b1, CONV_CONTROL_OFS, 32'(8'h84 + r));
        end
        do begin
            apb(1'b0, CONV_CONTROL_OFS, 32'h0);
            n++;
        end while (rdata[EOC_BIT] !== 1'b1 && n < 2000);
        chk(rdata, 32'(8'h88 + r), "end flag done");
        if (n >= 2000) print_verdict();
        n = cyc - t0;
        chk(n >= ex - 4 * dv[k] && n <= ex + 4 * dv[k] + 8, 1, "conv time");
        rd(RESULT_OFS, 32'(level >> (12 - nb[r])), "result");
    endtask : conv
    //////////////////////////////////////////////////
    initial begin
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        for (int a = 0; a <= 32; a += 4) begin
            rd(8'(a), 32'h0, "reset value");
        end
        rd(8'h24, 32'h0, "unmapped read");
        chk(rerr, 1, "unmapped error");
        apb(1'b1, HIGH_REF_CONTROL_OFS, 32'h7);
        wt(2);
        chk(refSel, 32'h4, "external ref");
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, HIGH_REF_CONTROL_OFS, 32'(i));
            wt(2);
            chk(refSel, 32'(i), "internal ref");
        end
        for (int i = 0; i < 32; i++) begin
            apb(1'b1, CHANNEL_OFS, 32'(i));
            wt(2);
            chk(muxSel.on, 32'(i >= 16 && i < 28), "gate");
            if (muxSel.on === 1'b1) chk(muxSel.sel, 32'(i % 16), "channel");
        end
        apb(1'b1, ANALOG_PIN_CONFIG_OFS, 32'hA5);
        apb(1'b1, CONV_CONTROL_OFS, 32'h50);
        wt(2);
        chk(pinAnalog, 32'h5A5, "pin map");
        apb(1'b1, CHANNEL_OFS, 32'h12);
        apb(1'b1, IRQ_ENABLE_OFS, 32'h1);
        conv(2, 0, 0, 1'b1);
        wt(2);
        chk(convIrq, 1, "irq raised");
        chk(coreEnable, 1, "core on");
        apb(1'b1, IRQ_CLEAR_OFS, 32'h1);
        wt(2);
        chk(convIrq, 0, "irq cleared");
        @(posedge clk);
        globalIrqEnable <= 1'b0;
        conv(3, 1, 1, 1'b0);
        wt(2);
        chk(convIrq, 0, "global mask");
        rd(IRQ_STATUS_OFS, 32'h1, "status sticky");
        globalIrqEnable <= 1'b1;
        wt(2);
        chk(convIrq, 1, "global unmask");
        apb(1'b1, IRQ_ENABLE_OFS, 32'h0);
        wt(2);
        chk(convIrq, 0, "local mask");
        conv(1, 2, 2, 1'b0);
        conv(0, 3, 3, 1'b0);
        print_verdict();
    end
endmodule : testbench

// File: verilog/sac_clk_div.sv
`timescale 1ns/1ps

// Makes the instruction-clock enable and, from it, the converter clock enable.
module sac_clk_div #(
    parameter int INSTR_DIV = sac_pkg::INSTR_DIV
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic run,
    input wire logic [1:0] clkSel,
    output logic convTick
);
    import sac_pkg::*;

    typedef struct packed {
        logic [7:0] instrCnt;
        logic [4:0] convCnt;
        logic tick;
    } sac_div_s;

    sac_div_s s_reg;
    sac_div_s s_next;

    // Divide ratio of the converter clock against the instruction clock.
    function automatic logic [4:0] ratio(input logic [1:0] sel);
        case (sel)
            2'b00: ratio = 5'd16;
            2'b01: ratio = 5'd8;
            2'b10: ratio = 5'd1;
            default: ratio = 5'd2;
        endcase
    endfunction : ratio

    // Counters restart while idle so every conversion starts on a whole period.
    always_comb begin
        s_next = s_reg;
        s_next.tick = 1'b0;
        if (!run) begin
            s_next.instrCnt = 8'h00;
            s_next.convCnt = 5'h00;
        end else if (s_reg.instrCnt == 8'(INSTR_DIV - 1)) begin
            s_next.instrCnt = 8'h00;
            // R1: divided converter clock
            // R15: divisor code decode
            if (s_reg.convCnt == ratio(clkSel) - 5'd1) begin
                s_next.convCnt = 5'h00;
                s_next.tick = 1'b1;
            end else begin
                s_next.convCnt = s_reg.convCnt + 5'd1;
            end
        end else begin
            s_next.instrCnt = s_reg.instrCnt + 8'd1;
        end
    end

    // State register.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign convTick = s_reg.tick;

endmodule : sac_clk_div

// File: verilog/sac_pkg.sv
package sac_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Register byte offsets on the APB port.
    localparam logic [7:0] CONV_CONTROL_OFS = 8'h00;
    localparam logic [7:0] TIMING_OFS = 8'h04;
    localparam logic [7:0] HIGH_REF_CONTROL_OFS = 8'h08;
    localparam logic [7:0] CHANNEL_OFS = 8'h0C;
    localparam logic [7:0] ANALOG_PIN_CONFIG_OFS = 8'h10;
    localparam logic [7:0] RESULT_OFS = 8'h14;
    localparam logic [7:0] IRQ_STATUS_OFS = 8'h18;
    localparam logic [7:0] IRQ_CLEAR_OFS = 8'h1C;
    localparam logic [7:0] IRQ_ENABLE_OFS = 8'h20;

    ////////////////////////////////////////////////////////////////////////////////
    // Field positions.
    localparam int RES_LSB = 0;
    localparam int START_BIT = 2;
    localparam int EOC_BIT = 3;
    localparam int PIN_HI_LSB = 4;
    localparam int ENABLE_BIT = 7;
    localparam int CLK_SEL_LSB = 0;
    localparam int SAMPLE_SEL_LSB = 2;
    localparam int INT_REF_LSB = 0;
    localparam int EXT_REF_BIT = 2;
    localparam int CHAN_LSB = 0;
    localparam int GATE_BIT = 4;

    ////////////////////////////////////////////////////////////////////////////////
    // Reset values and codes.
    localparam logic [1:0] RES_RESET = 2'h0;
    localparam logic [1:0] CLK_SEL_RESET = 2'h0;
    localparam logic [1:0] SAMPLE_SEL_RESET = 2'h0;
    localparam logic [1:0] INT_REF_RESET = 2'h0;
    localparam logic [3:0] CHAN_RESET = 4'h0;
    localparam logic [7:0] PIN_CFG_RESET = 8'h00;
    localparam logic EOC_RESET = 1'b0;
    localparam logic [3:0] CHAN_LAST = 4'hB;
    localparam int RESULT_W = 12;
    localparam int FINISH_TICKS = 2;

    ////////////////////////////////////////////////////////////////////////////////
    // Timing: the instruction clock is the 20 MHz system clock divided down.
    localparam int CLK_HZ = 20000000;
    localparam int INSTR_HZ = 5000000;
    localparam int INSTR_DIV = CLK_HZ / INSTR_HZ;

    // Sequencer states.
    typedef enum logic [1:0] {
        SAC_IDLE = 2'b00,
        SAC_SAMPLE = 2'b01,
        SAC_CONVERT = 2'b10,
        SAC_FINISH = 2'b11
    } sac_state_e;

    // High reference choice as seen by the analog core.
    typedef struct packed {
        logic ext;
        logic [1:0] intSel;
    } sac_ref_s;

    // Input multiplexer drive as seen by the analog core.
    typedef struct packed {
        logic on;
        logic [3:0] sel;
    } sac_mux_s;

endpackage : sac_pkg

// File: verilog/sac_sar_seq.sv
`timescale 1ns/1ps

// Sampling window, bit trials and the closing periods of one conversion.
module sac_sar_seq (
    input wire logic clk,
    input wire logic rstn,
    input wire logic tick,
    input wire logic enable,
    input wire logic startReq,
    input wire logic [1:0] sampleSel,
    input wire logic [1:0] resSel,
    input wire logic cmpHigh,
    output logic busy,
    output logic sampling,
    output logic [11:0] dacCode,
    output logic [11:0] result,
    output logic done
);
    import sac_pkg::*;

    typedef struct packed {
        sac_state_e st;
        logic [3:0] cnt;
        logic [3:0] bitIdx;
        logic [11:0] code;
        logic [11:0] res;
        logic done;
    } sac_seq_s;

    sac_seq_s s_reg;
    sac_seq_s s_next;
    logic [3:0] lowBit;

    // R17: resolution sets the last trial bit
    assign lowBit = (resSel == 2'b00) ? 4'd4 : (resSel == 2'b01) ? 4'd2 : 4'd0;

    // Sample, trial and closing states step once per converter clock period; idle leaves on the start pulse at once.
    always_comb begin
        s_next = s_reg;
        s_next.done = 1'b0;
        case (s_reg.st)
            SAC_IDLE: begin
                if (startReq && enable) begin
                    s_next.st = SAC_SAMPLE;
                    // R16: window length decode
                    s_next.cnt = 4'((4'd1 << sampleSel) - 4'd1);
                    s_next.code = 12'h000;
                end
            end
            SAC_SAMPLE: begin
                // R2: sample before trials
                if (tick) begin
                    if (s_reg.cnt == 4'd0) begin
                        s_next.st = SAC_CONVERT;
                        s_next.bitIdx = 4'd11;
                        s_next.code = 12'h800;
                    end else begin
                        s_next.cnt = s_reg.cnt - 4'd1;
                    end
                end
            end
            SAC_CONVERT: begin
                // R7: one trial per bit
                if (tick) begin
                    if (!cmpHigh) begin
                        s_next.code[s_reg.bitIdx] = 1'b0;
                    end
                    if (s_reg.bitIdx == lowBit) begin
                        s_next.st = SAC_FINISH;
                        s_next.cnt = 4'(FINISH_TICKS - 1);
                    end else begin
                        s_next.bitIdx = s_reg.bitIdx - 4'd1;
                        s_next.code[s_reg.bitIdx - 4'd1] = 1'b1;
                    end
                end
            end
            SAC_FINISH: begin
                // R18: two closing periods
                if (tick) begin
                    if (s_reg.cnt == 4'd0) begin
                        s_next.st = SAC_IDLE;
                        s_next.res = s_reg.code >> lowBit;
                        s_next.done = 1'b1;
                    end else begin
                        s_next.cnt = s_reg.cnt - 4'd1;
                    end
                end
            end
            default: s_next.st = SAC_IDLE;
        endcase
        // R3: disabled converter stops
        if (!enable) begin
            s_next.st = SAC_IDLE;
            s_next.done = 1'b0;
        end
    end

    // State register.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign busy = (s_reg.st != SAC_IDLE);
    assign sampling = (s_reg.st == SAC_SAMPLE);
    assign dacCode = s_reg.code;
    assign result = s_reg.res;
    assign done = s_reg.done;

endmodule : sac_sar_seq

// File: verilog/sac_top.sv
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// R1: Converter clock divides instruction clock.
// R2: Sampling lasts one, two, four, eight periods.
// R3: Software enables converter before any start.
// R4: Writing start converts the selected input.
// R5: End flag low while converting, else high; it resets low and stays low until the first conversion ends.
// R6: End flag rise interrupts when both enabled.
// R7: Results are up to twelve bits.
// R8: External select takes reference from pin.
// R9: Internal field picks supply, 4V, 3V, 2V.
// R10: Channel gate low connects no source.
// R11: Channel code picks pins, quarter supply.
// R12: Pin config bits map to port pins.
// R13: Analog config disables digital pin use.
// R14: Software sets analog pins input, unpulled.
// R15: Clock code picks sixteen, eight, one, two.
// R16: Width code picks one, two, four, eight.
// R17: Resolution code picks 8, 10, 12 bits.
// R18: Conversion takes width plus bits plus two.
// R19: Start clears end flag; busy start ignored.
module sac_top #(
    parameter int INSTR_DIV = sac_pkg::INSTR_DIV
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic globalIrqEnable,
    input wire logic cmpOut,
    output logic convIrq,
    output logic coreEnable,
    output logic sampling,
    output logic [11:0] dacCode,
    output sac_pkg::sac_ref_s refSel,
    output sac_pkg::sac_mux_s muxSel,
    output logic [10:0] pinAnalog
);
    import sac_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Register state of the block, held as one packed word.
    typedef struct packed {
        logic cmpMeta;
        logic cmpSync;
        logic [1:0] resSel;
        logic [2:0] pinHi;
        logic convEnable;
        logic [1:0] clkSel;
        logic [1:0] sampleSel;
        logic refExt;
        logic [1:0] refInt;
        logic chanGate;
        logic [3:0] chanSel;
        logic [7:0] pinCfg;
        logic irqEn;
        logic irqStat;
        logic eoc;
        logic startPulse;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic irqOut;
        logic coreOn;
        sac_ref_s refOut;
        sac_mux_s muxOut;
        logic [10:0] pinOut;
    } sac_top_s;

    sac_top_s s_reg;
    sac_top_s s_next;

    // Sequencer and divider links.
    logic convTick;
    logic busy;
    logic done;
    logic [11:0] result;

    // Decoded phases of the APB transfer.
    logic setupPhase;
    logic writeAccess;

    // True for every offset that has a register behind it.
    function automatic logic mapped(input logic [7:0] addr);
        case (addr)
            CONV_CONTROL_OFS, TIMING_OFS, HIGH_REF_CONTROL_OFS, CHANNEL_OFS,
            ANALOG_PIN_CONFIG_OFS, RESULT_OFS, IRQ_STATUS_OFS, IRQ_CLEAR_OFS,
            IRQ_ENABLE_OFS: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    endfunction : mapped

    ////////////////////////////////////////////////////////////////////////////////
    // Converter clock enable. It only runs during a conversion, which saves
    // switching while idle and lines the first period up with the start.
    sac_clk_div #(
        .INSTR_DIV(INSTR_DIV)
    ) u_div (
        .clk(clk),
        .rstn(rstn),
        .run(busy),
        .clkSel(s_reg.clkSel),
        .convTick(convTick)
    );

    // Successive-approximation sequencer.
    sac_sar_seq u_seq (
        .clk(clk),
        .rstn(rstn),
        .tick(convTick),
        .enable(s_reg.convEnable),
        .startReq(s_reg.startPulse),
        .sampleSel(s_reg.sampleSel),
        .resSel(s_reg.resSel),
        .cmpHigh(s_reg.cmpSync),
        .busy(busy),
        .sampling(sampling),
        .dacCode(dacCode),
        .result(result),
        .done(done)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // The access phase always completes in its first cycle, because pready is
    // raised from the setup cycle. Write data land at that edge only.
    assign setupPhase = psel && !penable;
    assign writeAccess = psel && penable && s_reg.pready && pwrite && !s_reg.pslverr;

    ////////////////////////////////////////////////////////////////////////////////
    // Next-state logic for the bus slave, the control bits and the flags.
    always_comb begin
        s_next = s_reg;
        // The comparator is analog and asynchronous to clk, so it is
        // resynchronised. The converter clock is at least four clk periods,
        // which keeps this latency well inside one trial.
        s_next.cmpMeta = cmpOut;
        s_next.cmpSync = s_reg.cmpMeta;
        s_next.startPulse = 1'b0;
        s_next.pready = 1'b0;
        s_next.pslverr = 1'b0;

        // Setup cycle: decode and capture the read word.
        if (setupPhase) begin
            s_next.pready = 1'b1;
            s_next.pslverr = !mapped(paddr);
            s_next.prdata = 32'h0000_0000;
            if (!pwrite) begin
                case (paddr)
                    CONV_CONTROL_OFS: begin
                        s_next.prdata[RES_LSB +: 2] = s_reg.resSel;
                        // R5: end flag readback
                        s_next.prdata[EOC_BIT] = s_reg.eoc;
                        s_next.prdata[PIN_HI_LSB +: 3] = s_reg.pinHi;
                        s_next.prdata[ENABLE_BIT] = s_reg.convEnable;
                    end
                    TIMING_OFS: begin
                        s_next.prdata[CLK_SEL_LSB +: 2] = s_reg.clkSel;
                        s_next.prdata[SAMPLE_SEL_LSB +: 2] = s_reg.sampleSel;
                    end
                    HIGH_REF_CONTROL_OFS: begin
                        s_next.prdata[INT_REF_LSB +: 2] = s_reg.refInt;
                        s_next.prdata[EXT_REF_BIT] = s_reg.refExt;
                    end
                    CHANNEL_OFS: begin
                        s_next.prdata[CHAN_LSB +: 4] = s_reg.chanSel;
                        s_next.prdata[GATE_BIT] = s_reg.chanGate;
                    end
                    ANALOG_PIN_CONFIG_OFS: begin
                        s_next.prdata[7:0] = s_reg.pinCfg;
                    end
                    RESULT_OFS: begin
                        s_next.prdata[RESULT_W - 1:0] = result;
                    end
                    IRQ_STATUS_OFS: begin
                        s_next.prdata[0] = s_reg.irqStat;
                    end
                    IRQ_ENABLE_OFS: begin
                        s_next.prdata[0] = s_reg.irqEn;
                    end
                    // The clear register and unmapped offsets read as zero.
                    default: s_next.prdata = 32'h0000_0000;
                endcase
            end
        end

        // Access edge of a write: store the addressed register.
        if (writeAccess) begin
            case (paddr)
                CONV_CONTROL_OFS: begin
                    s_next.resSel = pwdata[RES_LSB +: 2];
                    s_next.pinHi = pwdata[PIN_HI_LSB +: 3];
                    s_next.convEnable = pwdata[ENABLE_BIT];
                    // R3: start needs converter enabled
                    // R4: start bit launches conversion
                    // R19: busy start ignored, flag cleared
                    if (pwdata[START_BIT] && pwdata[ENABLE_BIT] && !busy) begin
                        s_next.startPulse = 1'b1;
                        s_next.eoc = 1'b0;
                    end
                end
                TIMING_OFS: begin
                    s_next.clkSel = pwdata[CLK_SEL_LSB +: 2];
                    s_next.sampleSel = pwdata[SAMPLE_SEL_LSB +: 2];
                end
                HIGH_REF_CONTROL_OFS: begin
                    s_next.refInt = pwdata[INT_REF_LSB +: 2];
                    s_next.refExt = pwdata[EXT_REF_BIT];
                end
                CHANNEL_OFS: begin
                    s_next.chanSel = pwdata[CHAN_LSB +: 4];
                    s_next.chanGate = pwdata[GATE_BIT];
                end
                ANALOG_PIN_CONFIG_OFS: begin
                    s_next.pinCfg = pwdata[7:0];
                end
                IRQ_CLEAR_OFS: begin
                    if (pwdata[0]) begin
                        s_next.irqStat = 1'b0;
                    end
                end
                IRQ_ENABLE_OFS: begin
                    s_next.irqEn = pwdata[0];
                end
                // Read-only and unmapped offsets ignore writes.
                default: s_next.irqEn = s_reg.irqEn;
            endcase
        end

        // R5: end flag set at finish
        // R6: rising end flag latches event
        // The finishing event is applied after the clear, so an event in the
        // same cycle as a software clear is kept.
        // A start taken in the same cycle keeps the end flag low.
        if (done) begin
            s_next.eoc = !s_next.startPulse;
            s_next.irqStat = 1'b1;
        end

        // R6: both enables gate request
        s_next.irqOut = s_next.irqStat && s_next.irqEn && globalIrqEnable;

        ////////////////////////////////////////////////////////////////////////
        // Analog core controls, all registered on the way out.
        s_next.coreOn = s_next.convEnable;

        // R8: external reference overrides field
        // R9: internal reference code passed
        s_next.refOut.ext = s_next.refExt;
        s_next.refOut.intSel = s_next.refExt ? 2'b00 : s_next.refInt;

        // R10: gate low connects nothing
        // R11: codes above quarter supply unconnected
        s_next.muxOut.on = s_next.chanGate && (s_next.chanSel <= CHAN_LAST);
        s_next.muxOut.sel = s_next.chanSel;

        // R12: pin config bit mapping
        // R13: analog pins lose digital use
        s_next.pinOut = {s_next.pinHi, s_next.pinCfg};
    end

    ////////////////////////////////////////////////////////////////////////////////
    // State register with the documented reset values.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s_reg <= '0;
            s_reg.resSel <= RES_RESET;
            s_reg.clkSel <= CLK_SEL_RESET;
            s_reg.sampleSel <= SAMPLE_SEL_RESET;
            s_reg.refInt <= INT_REF_RESET;
            s_reg.chanSel <= CHAN_RESET;
            s_reg.pinCfg <= PIN_CFG_RESET;
            s_reg.eoc <= EOC_RESET;
        end else begin
            s_reg <= s_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs straight from the state register.
    assign prdata = s_reg.prdata;
    assign pready = s_reg.pready;
    assign pslverr = s_reg.pslverr;
    assign convIrq = s_reg.irqOut;
    assign coreEnable = s_reg.coreOn;
    assign refSel = s_reg.refOut;
    assign muxSel = s_reg.muxOut;
    assign pinAnalog = s_reg.pinOut;

endmodule : sac_top
